// *** ifeb_irq_bank.sv ***
// Purpose: interrupt flag and enable banks two, three and timer match
// Assumes: classic wishbone slave, one ack per access, one clock
// Notes:   LARGE selects the larger variant bank layout
//
// Functional notes
// R1 - Bank two holds flags in bits 7..4 and enables in 3..0, reset zero.
// R2 - A flag reads 1 while its request is pending and software may write it.
// R3 - In the small variant bank three holds only bits 4 and 0, others read 0.
// R4 - Bank three bit 4 is the eeprom request flag and bit 0 its enable.
// R5 - Large: bank three bit 5 is the serial port flag; 7, 6, 3, 2 read 0.
// R6 - Large: bank three bit 1 is the serial port enable.
// R7 - Timer bank bit 5 sets on timer 0 match A; small: bits 7, 6 read 0.
// R8 - Timer bank bit 4 sets on timer 0 match P; small: bits 3, 2 read 0.
// R9 - Timer bank bit 1 enables the timer 0 match A request.
// R10 - Timer bank bit 0 enables the timer 0 match P request.
// R11 - Large: timer bank bits 7, 6 are timer 1 flags, bits 3, 2 enables.
// R12 - A flag still sets when its enable is zero, but raises no interrupt.
// R13 - No interrupt reaches the core while the global enable is zero; only core_irq_o is gated by it, irq_o is not.
// R14 - A flag sets in the cycle its strobe is seen; the set beats a write.
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module ifeb_irq_bank #(
    parameter bit LARGE = 1'b1
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [ifeb_pkg::ADR_W-1:0]    wb_adr_i,
    input  wire logic [ifeb_pkg::DAT_W-1:0]    wb_dat_i,
    input  wire logic [3:0]                    wb_sel_i,
    output logic      [ifeb_pkg::DAT_W-1:0]    wb_dat_o,
    output logic                               wb_ack_o,
    input  wire ifeb_pkg::ifeb_events_t        events_i,
    output logic      [11:0]                   pend_o,
    output logic                               core_irq_o,
    output logic                               irq_o
);

    localparam int BW = ifeb_pkg::BANK_W;
    localparam int NE = ifeb_pkg::NUM_EV;
    // R3 R5 R7 R8 R11 variant bits
    localparam logic [BW-1:0] B3_IMPL = LARGE ?
        ifeb_pkg::BANK_THREE_LARGE : ifeb_pkg::BANK_THREE_SMALL;
    localparam logic [BW-1:0] TM_IMPL = LARGE ?
        ifeb_pkg::TIMER_BANK_LARGE : ifeb_pkg::TIMER_BANK_SMALL;

    // ========================================================
    // declarations
    logic                             ack_reg;
    logic [ifeb_pkg::DAT_W-1:0]       dat_reg;
    logic                             gie_reg;
    logic [NE-1:0]                    status_reg;
    logic [NE-1:0]                    status_next;
    logic [NE-1:0]                    mask_reg;
    logic [11:0]                      pend_reg;
    logic                             core_irq_reg;
    logic                             irq_reg;
    logic [NE-1:0]                    ev_vec;
    logic [ifeb_pkg::ADR_W-1:0]       adr_word;
    logic                             acc;
    logic                             wr;
    logic                             rd;
    logic [ifeb_pkg::NUM_BANK-1:0]    bank_hit;
    logic [BW-1:0]                    bank_q   [ifeb_pkg::NUM_BANK];
    logic [BW-1:0]                    bank_set [ifeb_pkg::NUM_BANK];
    logic [11:0]                      pend_comb;
    logic [ifeb_pkg::DAT_W-1:0]       rd_data;
    logic                             hit_glb;
    logic                             hit_st;
    logic                             hit_mk;
    logic                             hit_pd;

    // ========================================================
    // bus decode
    assign adr_word = {wb_adr_i[ifeb_pkg::ADR_W-1:2], 2'b00};
    assign acc      = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr       = acc & wb_we_i & wb_sel_i[0];
    assign rd       = acc & ~wb_we_i;
    assign bank_hit[0] = adr_word == ifeb_pkg::OFS_BANK_TWO;
    assign bank_hit[1] = adr_word == ifeb_pkg::OFS_BANK_THREE;
    assign bank_hit[2] = adr_word == ifeb_pkg::OFS_TIMER_BANK;
    assign hit_glb  = adr_word == ifeb_pkg::OFS_GLOBAL;
    assign hit_st   = adr_word == ifeb_pkg::OFS_EV_STATUS;
    assign hit_mk   = adr_word == ifeb_pkg::OFS_EV_MASK;
    assign hit_pd   = adr_word == ifeb_pkg::OFS_PENDING;

    // ========================================================
    // event set vectors
    // R1 bank two sources
    assign bank_set[0] = {events_i.low_voltage,
                          events_i.comparator_one,
                          events_i.serial_iface,
                          events_i.ext_pin_one,
                          4'h0};
    // R4 eeprom and serial port flags
    assign bank_set[1] = {2'b00,
                          events_i.serial_port,
                          events_i.eeprom,
                          4'h0};
    // R7 timer match flags
    assign bank_set[2] = {events_i.timer1_match_a,
                          events_i.timer1_match_p,
                          events_i.timer0_match_a,
                          events_i.timer0_match_p,
                          4'h0};
    assign ev_vec = events_i;

    // ========================================================
    // flag banks
    genvar g;
    generate
        for (g = 0; g < ifeb_pkg::NUM_BANK; g++) begin : g_bank
            localparam logic [BW-1:0] IMPL = (g == 0) ?
                ifeb_pkg::BANK_TWO_IMPL : ((g == 1) ? B3_IMPL : TM_IMPL);
            // R14 set beats write
            ifeb_flag_bank #(
                .IMPL    (IMPL)
            ) u_bank (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .wr_i    (wr & bank_hit[g]),
                .wdata_i (wb_dat_i[BW-1:0]),
                .set_i   (bank_set[g]),
                .q_o     (bank_q[g])
            );
            // R6 R9 R10 R12 flag gated by enable
            assign pend_comb[4*g+3:4*g] =
                bank_q[g][BW-1:ifeb_pkg::EN_SHIFT] &
                bank_q[g][ifeb_pkg::EN_SHIFT-1:0];
        end
    endgenerate

    // ========================================================
    // read data mux
    assign rd_data =
        bank_hit[0] ? {24'h00_0000, bank_q[0]} :
        bank_hit[1] ? {24'h00_0000, bank_q[1]} :
        bank_hit[2] ? {24'h00_0000, bank_q[2]} :
        hit_glb     ? {31'h0000_0000, gie_reg} :
        hit_st      ? {22'h00_0000, status_reg} :
        hit_mk      ? {22'h00_0000, mask_reg} :
        hit_pd      ? {20'h0_0000, pend_reg} :
        ifeb_pkg::DATA_ZERO;

    // ========================================================
    // event status, cleared by a read, set wins
    assign status_next = (status_reg & {NE{~(rd & hit_st)}}) | ev_vec;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= ifeb_pkg::DATA_ZERO;
        end else begin
            ack_reg <= acc;
            dat_reg <= rd ? rd_data : dat_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gie_reg    <= 1'b0;
            mask_reg   <= '0;
            status_reg <= '0;
        end else begin
            gie_reg    <= (wr & hit_glb) ?
                          wb_dat_i[ifeb_pkg::GIE_BIT] : gie_reg;
            mask_reg   <= (wr & hit_mk) ? wb_dat_i[NE-1:0] : mask_reg;
            status_reg <= status_next;
        end
    end

    // ========================================================
    // interrupt outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_reg     <= '0;
            core_irq_reg <= 1'b0;
            irq_reg      <= 1'b0;
        end else begin
            pend_reg     <= pend_comb;
            // R13 global enable gate
            core_irq_reg <= gie_reg & (|pend_comb);
            irq_reg      <= |(status_reg & mask_reg);
        end
    end

    assign wb_ack_o   = ack_reg;
    assign wb_dat_o   = dat_reg;
    assign pend_o     = pend_reg;
    assign core_irq_o = core_irq_reg;
    assign irq_o      = irq_reg;

    // ========================================================
    // assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_acc;
        wb_cyc_i && wb_stb_i && !ack_reg;
    endsequence

    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    property p_ack_pulse;
        s_acc |=> s_ack_once;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack not a single pulse");

    property p_bank_two_write;
        (wr && bank_hit[0] && bank_set[0] == 8'h00)
            |=> bank_q[0] == $past(wb_dat_i[BW-1:0]);
    endproperty
    a_bank_two_write: assert property (p_bank_two_write) // R1 R2
        else $error("bank two write lost");

    property p_flag_set;
        events_i.low_voltage |=> bank_q[0][ifeb_pkg::LV_FLAG_BIT];
    endproperty
    a_flag_set: assert property (p_flag_set) // R14
        else $error("event did not set flag");

    property p_bank_three_unimpl;
        (bank_q[1] & ~B3_IMPL) == 8'h00;
    endproperty
    a_bank_three_unimpl: assert property (p_bank_three_unimpl) // R3 R5
        else $error("bank three unimplemented bit set");

    property p_eeprom_flag;
        events_i.eeprom |=> bank_q[1][ifeb_pkg::EE_FLAG_BIT];
    endproperty
    a_eeprom_flag: assert property (p_eeprom_flag) // R4
        else $error("eeprom flag not set");

    property p_uart_enable;
        (bank_q[1][ifeb_pkg::UART_FLAG_BIT] && bank_q[1][1])
            |=> pend_o[5] == LARGE;
    endproperty
    a_uart_enable: assert property (p_uart_enable) // R6
        else $error("serial port pending wrong");

    property p_timer_unimpl;
        (bank_q[2] & ~TM_IMPL) == 8'h00;
    endproperty
    a_timer_unimpl: assert property (p_timer_unimpl) // R7 R8
        else $error("timer bank unimplemented bit set");

    property p_timer_flags;
        events_i.timer0_match_a && events_i.timer0_match_p
            |=> bank_q[2][ifeb_pkg::T0A_FLAG_BIT:ifeb_pkg::T0P_FLAG_BIT]
                == 2'b11;
    endproperty
    a_timer_flags: assert property (p_timer_flags) // R7 R8
        else $error("timer 0 match flags not set");

    property p_timer_enables;
        (bank_q[2][5:4] & bank_q[2][1:0]) == 2'b00 |=> pend_o[9:8] == 2'b00;
    endproperty
    a_timer_enables: assert property (p_timer_enables) // R9 R10
        else $error("timer 0 pending without enable");

    property p_timer_one;
        events_i.timer1_match_a |=>
            bank_q[2][ifeb_pkg::T1A_FLAG_BIT] == LARGE;
    endproperty
    a_timer_one: assert property (p_timer_one) // R11
        else $error("timer 1 flag wrong for variant");

    property p_disabled_flag;
        (bank_q[0][ifeb_pkg::LV_FLAG_BIT] && !bank_q[0][3])
            |=> !pend_o[3];
    endproperty
    a_disabled_flag: assert property (p_disabled_flag) // R12
        else $error("disabled source reported pending");

    property p_global_off;
        !gie_reg |=> !core_irq_o;
    endproperty
    a_global_off: assert property (p_global_off) // R13
        else $error("core interrupt with global enable off");

    property p_global_on;
        gie_reg && (|pend_comb) |=> core_irq_o;
    endproperty
    a_global_on: assert property (p_global_on) // R13
        else $error("core interrupt missing");

    property p_status_irq;
        (|(status_reg & mask_reg)) |=> irq_o;
    endproperty
    a_status_irq: assert property (p_status_irq)
        else $error("masked status did not raise irq");

    property p_uart_flag;
        events_i.serial_port |=>
            bank_q[1][ifeb_pkg::UART_FLAG_BIT] == LARGE;
    endproperty
    a_uart_flag: assert property (p_uart_flag) // R5
        else $error("serial port flag wrong for variant");

    property p_timer_one_p;
        events_i.timer1_match_p |=>
            bank_q[2][ifeb_pkg::T1P_FLAG_BIT] == LARGE;
    endproperty
    a_timer_one_p: assert property (p_timer_one_p) // R11
        else $error("timer 1 match p flag wrong for variant");

    property p_set_beats_write;
        (wr && bank_hit[0] && events_i.ext_pin_one)
            |=> bank_q[0][ifeb_pkg::PIN1_FLAG_BIT];
    endproperty
    a_set_beats_write: assert property (p_set_beats_write) // R14
        else $error("write beat a coincident event");

    property p_flag_clear;
        (wr && bank_hit[1] && !events_i.eeprom &&
            !wb_dat_i[ifeb_pkg::EE_FLAG_BIT])
            |=> !bank_q[1][ifeb_pkg::EE_FLAG_BIT];
    endproperty
    a_flag_clear: assert property (p_flag_clear) // R2
        else $error("eeprom flag not cleared by write");

    property p_t0a_pend;
        (bank_q[2][ifeb_pkg::T0A_FLAG_BIT] && bank_q[2][1])
            |=> pend_o[9];
    endproperty
    a_t0a_pend: assert property (p_t0a_pend) // R9
        else $error("timer 0 match a pending missing");

    property p_t0p_pend;
        (bank_q[2][ifeb_pkg::T0P_FLAG_BIT] && bank_q[2][0])
            |=> pend_o[8];
    endproperty
    a_t0p_pend: assert property (p_t0p_pend) // R10
        else $error("timer 0 match p pending missing");

    property p_irq_masked;
        !(|(status_reg & mask_reg)) |=> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("irq without masked status");

    property p_status_clear;
        (rd && hit_st && !(|ev_vec)) |=> !(|status_reg);
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status not cleared by read");

endmodule // ifeb_irq_bank

// *** ifeb_pkg.sv ***
// Purpose: constants and types of the interrupt flag and enable banks
// Assumes: 32-bit classic wishbone, 8-bit banks in the low byte lane
// Notes:   every bank pairs flag bit n+4 with enable bit n
package ifeb_pkg;

    // ========================================================
    // bus and sizes
    localparam int ADR_W    = 8;
    localparam int DAT_W    = 32;
    localparam int BANK_W   = 8;
    localparam int NUM_BANK = 3;
    localparam int NUM_EV   = 10;
    localparam int EN_SHIFT = 4;

    // ========================================================
    // register offsets (byte addresses)
    localparam logic [ADR_W-1:0] OFS_BANK_TWO   = 8'h00;
    localparam logic [ADR_W-1:0] OFS_BANK_THREE = 8'h04;
    localparam logic [ADR_W-1:0] OFS_TIMER_BANK = 8'h08;
    localparam logic [ADR_W-1:0] OFS_GLOBAL     = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_EV_STATUS  = 8'h10;
    localparam logic [ADR_W-1:0] OFS_EV_MASK    = 8'h14;
    localparam logic [ADR_W-1:0] OFS_PENDING    = 8'h18;

    // ========================================================
    // field positions
    localparam int LV_FLAG_BIT   = 7;
    localparam int CMP1_FLAG_BIT = 6;
    localparam int SIM_FLAG_BIT  = 5;
    localparam int PIN1_FLAG_BIT = 4;
    localparam int UART_FLAG_BIT = 5;
    localparam int EE_FLAG_BIT   = 4;
    localparam int T1A_FLAG_BIT  = 7;
    localparam int T1P_FLAG_BIT  = 6;
    localparam int T0A_FLAG_BIT  = 5;
    localparam int T0P_FLAG_BIT  = 4;
    localparam int GIE_BIT       = 0;

    // ========================================================
    // implemented bits and reset values
    localparam logic [BANK_W-1:0] BANK_TWO_IMPL     = 8'hFF;
    localparam logic [BANK_W-1:0] BANK_THREE_SMALL  = 8'h11;
    localparam logic [BANK_W-1:0] BANK_THREE_LARGE  = 8'h33;
    localparam logic [BANK_W-1:0] TIMER_BANK_SMALL  = 8'h33;
    localparam logic [BANK_W-1:0] TIMER_BANK_LARGE  = 8'hFF;
    localparam logic [BANK_W-1:0] BANK_RESET        = 8'h00;
    localparam logic [DAT_W-1:0]  DATA_ZERO         = 32'h0000_0000;

    // ========================================================
    // peripheral event strobes, one cycle each
    typedef struct packed {
        logic low_voltage;
        logic comparator_one;
        logic serial_iface;
        logic ext_pin_one;
        logic eeprom;
        logic serial_port;
        logic timer0_match_a;
        logic timer0_match_p;
        logic timer1_match_a;
        logic timer1_match_p;
    } ifeb_events_t;

endpackage

// *** ifeb_flag_bank.sv ***
// Purpose: one 8-bit flag and enable bank
// Assumes: set strobes from the same clock domain
// Notes:   bits outside IMPL stay zero
`timescale 1ns/1ps
module ifeb_flag_bank #(
    parameter logic [7:0] IMPL = 8'hFF
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] set_i,
    output logic      [7:0] q_o
);

    logic [7:0] q_reg;
    logic [7:0] q_next;

    // ========================================================
    // next value: set wins over the written value
    // R2 R14 write then set
    assign q_next = ((wr_i ? wdata_i : q_reg) | set_i) & IMPL;
    assign q_o    = q_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= ifeb_pkg::BANK_RESET;
        end else begin
            q_reg <= q_next;
        end
    end

endmodule // ifeb_flag_bank

// *** ifeb_evt_src.sv ***
// Purpose: model of the peripheral event sources
// Assumes: one clock shared with the flag banks
// Notes:   a held request gives a single one-cycle strobe
`timescale 1ns/1ps
module ifeb_evt_src (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [9:0]       fire_i,
    output ifeb_pkg::ifeb_events_t events_o
);
    // ====================
    // edge detect of requests
    logic [9:0] fire_reg;

    always_ff @(posedge clk_i) begin
        fire_reg <= rst_i ? 10'h000 : fire_i;
    end

    assign events_o = ifeb_pkg::ifeb_events_t'(fire_i & ~fire_reg);
endmodule // ifeb_evt_src

// *** ifeb_irq_bank_tb.sv ***
// Purpose: self-checking bench of the flag and enable banks
// Assumes: large and small variants share bus and events
// Notes:   random data from a fixed-seed lfsr
`timescale 1ns/1ps
module ifeb_irq_bank_tb;
    // ====================
    // drive and observe
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0]  sel = 4'h1;
    logic [9:0]  fire = 10'h000;
    logic [31:0] seed = 32'hfc63_717f;
    logic [31:0] dl, ds, rl, rs;
    logic        ack_l, ack_s, cil, cis, il, is_s;
    logic [11:0] pl, ps;
    ifeb_pkg::ifeb_events_t ev;
    int          err_total = 0;
    int          comparisons = 0;
    int          evb [0:9] = '{6, 7, 4, 5, 5, 4, 4, 5, 6, 7};

    always #2.5 clk_i = ~clk_i;

    ifeb_evt_src src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
        .events_o(ev));
    ifeb_irq_bank #(.LARGE(1'b1)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dl), .wb_ack_o(ack_l),
        .events_i(ev), .pend_o(pl), .core_irq_o(cil), .irq_o(il));
    ifeb_irq_bank #(.LARGE(1'b0)) dut_small (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(ds), .wb_ack_o(ack_s),
        .events_i(ev), .pend_o(ps), .core_irq_o(cis), .irq_o(is_s));

    // ====================
    // expectations
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [7:0] impl(input logic [7:0] a, input bit big);
        if (a == 8'h00) return 8'hff;
        if (a == 8'h04) return big ? 8'h33 : 8'h11;
        return big ? 8'hff : 8'h33;
    endfunction

    // ====================
    // tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [9:0] f);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        fire <= f;
        do begin
            @(posedge clk_i);
            fire <= 10'h000;
            n++;
        end while (ack_l !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            close_out();
        end else begin
            chk("ack_small", 32'h1, {31'h0, ack_s});
            rl = dl;
            rs = ds;
            cyc <= 1'b0;
        end
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] el, input logic [31:0] es);
        bus(1'b0, a, 32'h0000_0000, 10'h000);
        chk(nm, el, rl);
        chk(nm, es, rs);
    endtask

    task automatic pulse(input logic [9:0] f);
        @(posedge clk_i);
        fire <= f;
        @(posedge clk_i);
        fire <= 10'h000;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    // ====================
    // main sequence
    initial begin
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] m;
        logic [11:0] p;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            rdchk("bank_reset", 8'(4 * k), 32'h0, 32'h0);
        end
        for (int k = 0; k < 12; k++) begin
            seed = nxt(seed);
            a = (k < 3) ? 8'(4 * k) : 8'(4 * (seed[9:8] % 3));
            b = (k < 3) ? 8'hff : seed[7:0];
            sel <= {seed[12:10], 1'b1};
            bus(1'b1, a, {seed[31:8], b}, 10'h000);
            rdchk("bank_rw", a, {24'h0, b & impl(a, 1'b1)},
                  {24'h0, b & impl(a, 1'b0)});
        end
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, 8'(4 * k), 32'h0, 10'h000);
        end
        sel <= 4'he;
        bus(1'b1, 8'h00, 32'h0000_00ff, 10'h000);
        rdchk("sel_ignored", 8'h00, 32'h0, 32'h0);
        sel <= 4'h1;
        for (int i = 0; i < 10; i++) begin
            a = (i >= 6) ? 8'h00 : (i >= 4) ? 8'h04 : 8'h08;
            b = 8'h01 << (evb[i] - 4);
            m = impl(a, 1'b0);
            p = 12'h001 << (evb[i] - 4 + ((i >= 6) ? 0 : (i >= 4) ? 4 : 8));
            bus(1'b1, a, {24'h0, b}, 10'h000);
            pulse(10'h001 << i);
            rdchk("flag_set", a, {24'h0, (b | b << 4) & impl(a, 1'b1)},
                  {24'h0, (b | b << 4) & m});
            chk("pend", {8'h0, p, m[evb[i]] ? p : 12'h000},
                {8'h0, pl, ps});
            chk("core_irq_off", 32'h0, {30'h0, cil, cis});
            bus(1'b1, a, 32'h0, 10'h000);
            rdchk("flag_clr", a, 32'h0, 32'h0);
        end
        bus(1'b1, 8'h0c, 32'h1, 10'h000);
        bus(1'b1, 8'h00, 32'h11, 10'h000);
        settle();
        chk("core_irq_on", 32'h3, {30'h0, cil, cis});
        bus(1'b1, 8'h00, 32'h10, 10'h000);
        settle();
        chk("core_irq_dis", 32'h0, {30'h0, cil, cis});
        bus(1'b1, 8'h00, 32'h11, 10'h000);
        bus(1'b1, 8'h0c, 32'h0, 10'h000);
        settle();
        chk("core_irq_glob", 32'h0, {30'h0, cil, cis});
        bus(1'b1, 8'h00, 32'h0, 10'h200);
        rdchk("set_wins", 8'h00, 32'h80, 32'h80);
        bus(1'b1, 8'h14, 32'h200, 10'h000);
        bus(1'b0, 8'h10, 32'h0, 10'h000);
        pulse(10'h200);
        settle();
        chk("irq_on", 32'h3, {30'h0, il, is_s});
        rdchk("status", 8'h10, 32'h200, 32'h200);
        settle();
        chk("irq_clr", 32'h0, {30'h0, il, is_s});
        pulse(10'h100);
        settle();
        chk("irq_mask", 32'h0, {30'h0, il, is_s});
        seed = nxt(seed);
        bus(1'b1, 8'h1c, seed, 10'h000);
        rdchk("unmapped", 8'h1c, 32'h0, 32'h0);
        close_out();
    end
endmodule // ifeb_irq_bank_tb
